// *** rtl/sar_seq_pkg.sv ***
// Constants and types shared by the conversion sequencer and its trial register
// Contract
// R1 - During acquisition, sample switches closed and array plates tied to the inputs.
// R2 - A rising convert_start from the host ends acquisition and starts conversion.
// R3 - Open both sample switches first, then move arrays from inputs to ground.
// R4 - Sixteen binary-weighted trial steps, half the previous, from MSB down to LSB.
// R5 - Decide one bit at a time, MSB first, toggling elements toward comparator balance.
// R6 - Keep a trial bit when input is not exceeded, else clear it.
// R7 - When the search ends, present the code and drop busy.
// R8 - Conversion timed by an internal clock, independent of the serial clock.
// R9 - Result is 16-bit two's complement, zero input gives 0x0000.
// R10 - Over positive full scale, output saturates at 0x7FFF.
// R11 - Under negative full scale, output saturates at 0x8000.
// R12 - Span compression keeps the full code range over the reduced input span.
// R13 - Span compression is off after reset, on only after software writes it.
// R14 - While the clamp is active, set the overvoltage clamp flag.
// R15 - Clamp flag is sticky and clears only when software reads its register.
// R16 - Clamp condition is also shown in the result status bits.
package sar_seq_pkg;

  // Resolution and code constants
  localparam int RES_BITS = 16;
  localparam logic [15:0] CODE_SIGN_FLIP = 16'h8000;
  localparam logic [15:0] CODE_POS_MAX = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_MIN = 16'h8000;
  localparam logic [15:0] TRIAL_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] TRIAL_ALL_ZERO = 16'h0000;

  // Conversion clock: one enable pulse every CONV_DIV pclk cycles
  localparam int CONV_DIV = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_CLAMP = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Field positions
  localparam int CTRL_SPAN_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_CLAMP_LIVE_BIT = 1;
  localparam int STATUS_VALID_BIT = 2;
  localparam int RESULT_OV_BIT = 16;
  localparam int CLAMP_FLAG_BIT = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CLAMP_BIT = 1;
  localparam int IRQ_W = 2;

  // Reset values
  localparam logic CTRL_SPAN_RESET = 1'b0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_ACQ,
    ST_OPEN_SW,
    ST_GROUND,
    ST_TRIAL,
    ST_DECIDE,
    ST_DONE
  } seq_state_e;

endpackage

// *** rtl/sar_trial_reg.sv ***
// Successive-approximation trial register with a walking bit pointer
`timescale 1ns/100ps
module sar_trial_reg
  import sar_seq_pkg::*;
#(
  parameter int W = RES_BITS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Step controls
  input wire logic load,
  input wire logic set_step,
  input wire logic decide,
  input wire logic keep,
  // Trial state
  output logic [W-1:0] trial,
  output logic last_bit
);

  logic [W-1:0] trial_reg;
  logic [W-1:0] mask_reg;
  logic [W-1:0] trial_next;
  logic [W-1:0] mask_next;

  // Next trial: raise the pointed bit, then keep or drop it
  assign trial_next = load ? '0 :
                      set_step ? (trial_reg | mask_reg) :
                      (decide && !keep) ? (trial_reg & ~mask_reg) : trial_reg; // R6
  // Pointer halves the step each decision, MSB first
  assign mask_next = load ? {1'b1, {(W-1){1'b0}}} :
                     decide ? (mask_reg >> 1) : mask_reg; // R4 R5

  // Trial and pointer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial_reg <= '0;
      mask_reg <= '0;
    end else begin
      trial_reg <= trial_next;
      mask_reg <= mask_next;
    end
  end

  assign trial = trial_reg;
  assign last_bit = mask_reg[0];

endmodule

// *** rtl/sar_conversion_sequencer.sv ***
// Conversion sequencer of a 16-bit SAR converter with an APB register file
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module sar_conversion_sequencer
  import sar_seq_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host conversion start pin
  input wire logic convert_start,
  // Analog front end
  input wire logic comp_trial_high,
  input wire logic clamp_active,
  output logic sample_switch_pos,
  output logic sample_switch_neg,
  output logic array_to_inputs,
  output logic [15:0] dac_drive,
  output logic span_compress_en,
  // Result side
  output logic busy,
  output logic [15:0] result_code,
  output logic overvoltage_clamp_flag,
  output logic irq
);

  // Synchronisers for pins from outside the pclk domain
  logic [1:0] start_sync_reg;
  logic [1:0] comp_sync_reg;
  logic [1:0] clamp_sync_reg;
  logic start_prev_reg;
  logic start_rise;
  logic comp_s;
  logic clamp_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_sync_reg <= 2'b00;
      comp_sync_reg <= 2'b00;
      clamp_sync_reg <= 2'b00;
      start_prev_reg <= 1'b0;
    end else begin
      start_sync_reg <= {start_sync_reg[0], convert_start};
      comp_sync_reg <= {comp_sync_reg[0], comp_trial_high};
      clamp_sync_reg <= {clamp_sync_reg[0], clamp_active};
      start_prev_reg <= start_sync_reg[1];
    end
  end

  // Rising edge of the synchronised start
  assign start_rise = start_sync_reg[1] && !start_prev_reg; // R2
  assign comp_s = comp_sync_reg[1];
  assign clamp_s = clamp_sync_reg[1];

  // Internal conversion clock enable
  logic [$clog2(DIV+1)-1:0] div_cnt_reg;
  logic conv_tick;

  assign conv_tick = (div_cnt_reg == '0); // R8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= '0;
    end else if (conv_tick) begin
      div_cnt_reg <= ($clog2(DIV+1))'(DIV - 1);
    end else begin
      div_cnt_reg <= div_cnt_reg - 1'b1;
    end
  end

  // Sequencer state
  seq_state_e state_reg;
  seq_state_e state_next;
  logic trial_last;
  logic [15:0] trial;
  logic load_trial;
  logic set_step;
  logic decide_step;
  logic keep_bit;

  // Next-state logic; each step from ST_OPEN_SW to ST_DECIDE waits for a conversion tick
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ACQ: begin
        if (start_rise) begin
          state_next = ST_OPEN_SW; // R2
        end
      end
      ST_OPEN_SW: begin
        if (conv_tick) begin
          state_next = ST_GROUND; // R3
        end
      end
      ST_GROUND: begin
        if (conv_tick) begin
          state_next = ST_TRIAL;
        end
      end
      ST_TRIAL: begin
        if (conv_tick) begin
          state_next = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (conv_tick) begin
          state_next = trial_last ? ST_DONE : ST_TRIAL; // R5
        end
      end
      ST_DONE: begin
        state_next = ST_ACQ; // R7
      end
      default: begin
        state_next = ST_ACQ;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_ACQ;
    end else begin
      state_reg <= state_next;
    end
  end

  // Trial register controls
  assign load_trial = (state_reg == ST_GROUND) && conv_tick;
  assign set_step = (state_reg == ST_TRIAL) && conv_tick;
  assign decide_step = (state_reg == ST_DECIDE) && conv_tick;
  assign keep_bit = !comp_s; // R6

  sar_trial_reg #(
    .W(RES_BITS)
  ) u_trial (
    .pclk(pclk),
    .presetn(presetn),
    .load(load_trial),
    .set_step(set_step),
    .decide(decide_step),
    .keep(keep_bit),
    .trial(trial),
    .last_bit(trial_last)
  );

  // Switch drive: closed only in ST_ACQ and ST_DONE, arrays tied to inputs in ST_ACQ, ST_DONE and ST_OPEN_SW
  logic acquiring;
  logic switches_open;
  assign acquiring = (state_reg == ST_ACQ) || (state_reg == ST_DONE);
  assign switches_open = !acquiring;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_switch_pos <= 1'b1;
      sample_switch_neg <= 1'b1;
      array_to_inputs <= 1'b1;
      dac_drive <= '0;
    end else begin
      sample_switch_pos <= !switches_open; // R1 R3
      sample_switch_neg <= !switches_open; // R1 R3
      array_to_inputs <= acquiring || (state_reg == ST_OPEN_SW); // R1 R3
      dac_drive <= (state_reg == ST_TRIAL || state_reg == ST_DECIDE) ? trial : '0; // R4
    end
  end

  // Offset binary to two's complement with explicit saturation
  function automatic logic [15:0] to_code(input logic [15:0] t);
    if (t == TRIAL_ALL_ONES) begin
      to_code = CODE_POS_MAX; // R10
    end else if (t == TRIAL_ALL_ZERO) begin
      to_code = CODE_NEG_MIN; // R11
    end else begin
      to_code = t ^ CODE_SIGN_FLIP; // R9 R12
    end
  endfunction

  // Result, busy and valid
  logic [15:0] result_reg;
  logic result_ov_reg;
  logic busy_reg;
  logic valid_reg;
  logic conv_done;
  logic clamp_flag_reg;

  assign conv_done = (state_reg == ST_DONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= RESULT_RESET;
      result_ov_reg <= 1'b0;
      busy_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      if (start_rise && state_reg == ST_ACQ) begin
        busy_reg <= 1'b1;
      end else if (conv_done) begin
        busy_reg <= 1'b0; // R7
      end
      if (conv_done) begin
        result_reg <= to_code(trial); // R7 R9
        result_ov_reg <= clamp_flag_reg || clamp_s; // R16
        valid_reg <= 1'b1;
      end
    end
  end

  assign busy = busy_reg;
  assign result_code = result_reg;

  // APB decode
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_en;
  logic sel_ctrl;
  logic sel_status;
  logic sel_result;
  logic sel_clamp;
  logic sel_istat;
  logic sel_imask;
  logic addr_hit;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign sel_ctrl = (paddr == OFS_CTRL);
  assign sel_status = (paddr == OFS_STATUS);
  assign sel_result = (paddr == OFS_RESULT);
  assign sel_clamp = (paddr == OFS_CLAMP);
  assign sel_istat = (paddr == OFS_IRQ_STAT);
  assign sel_imask = (paddr == OFS_IRQ_MASK);
  assign addr_hit = sel_ctrl | sel_status | sel_result | sel_clamp | sel_istat | sel_imask;
  assign wr_en = access_ph && pwrite && addr_hit && pstrb[0];
  assign rd_en = access_ph && !pwrite;

  // Control, sticky clamp flag and interrupt registers
  logic span_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic clamp_rd_clr;

  assign irq_set = {clamp_s, conv_done};
  assign irq_clr = (wr_en && sel_istat) ? pwdata[IRQ_W-1:0] : '0;
  assign clamp_rd_clr = rd_en && sel_clamp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_reg <= CTRL_SPAN_RESET; // R13
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_stat_reg <= '0;
      clamp_flag_reg <= 1'b0;
    end else begin
      if (wr_en && sel_ctrl) begin
        span_reg <= pwdata[CTRL_SPAN_BIT]; // R13
      end
      if (wr_en && sel_imask) begin
        irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      // Live clamp wins over a read clear
      clamp_flag_reg <= clamp_s || (clamp_flag_reg && !clamp_rd_clr); // R14 R15
    end
  end

  assign span_compress_en = span_reg; // R12
  assign overvoltage_clamp_flag = clamp_flag_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data captured in the setup phase
  logic [31:0] rdata_mux;
  logic [31:0] prdata_reg;

  assign rdata_mux =
    sel_ctrl ? {31'h0000_0000, span_reg} :
    sel_status ? {29'h0000_0000, valid_reg, clamp_s, busy_reg} :
    sel_result ? {15'h0000, result_ov_reg, result_reg} : // R16
    sel_clamp ? {31'h0000_0000, clamp_flag_reg} :
    sel_istat ? {30'h0000_0000, irq_stat_reg} :
    sel_imask ? {30'h0000_0000, irq_mask_reg} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_reg <= rdata_mux;
    end
  end

  // Zero-wait answer; unmapped addresses raise pslverr
  assign prdata = prdata_reg;
  assign pready = access_ph;
  assign pslverr = access_ph && !addr_hit;

endmodule

// *** verification/afe_model.sv ***
// Behavioural comparator of the analog front end facing the sequencer
`timescale 1ns/100ps
module afe_model (
  // Trial pattern and held input level, both offset binary
  input wire logic [15:0] dac_drive,
  input wire logic [15:0] level,
  // Comparator decision
  output logic comp_trial_high
);
  // High only while the trial strictly exceeds the held input
  assign comp_trial_high = dac_drive > level;
endmodule

// *** verification/sar_seq_assertions.sv ***
// Port checker for the conversion sequencer
`timescale 1ns/100ps
module sar_seq_checker
  import sar_seq_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // Pins
  input wire logic convert_start,
  input wire logic clamp_active,
  input wire logic sample_switch_pos,
  input wire logic sample_switch_neg,
  input wire logic array_to_inputs,
  input wire logic [15:0] dac_drive,
  input wire logic span_compress_en,
  input wire logic busy,
  input wire logic overvoltage_clamp_flag
);
  // Window for the tail of one whole conversion, after a fixed 100-cycle hold
  localparam int BMIN = 5 * DIV;
  localparam int BMAX = 15 * DIV;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Armed in acquisition, disarmed by the first non-zero trial pattern
  logic first_pending_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pending_reg <= 1'b0;
    end else if (array_to_inputs) begin
      first_pending_reg <= 1'b1;
    end else if (dac_drive != 16'h0000) begin
      first_pending_reg <= 1'b0;
    end
  end
  // Switch and array sequencing
  a_switch_pair: assert property (sample_switch_pos == sample_switch_neg)
    else $error("sample switches disagree");
  a_open_first: assert property ($fell(array_to_inputs) |-> !$past(sample_switch_pos))
    else $error("array grounded before switches opened");
  a_acq_tied: assert property (sample_switch_pos |-> array_to_inputs)
    else $error("switches closed with array off inputs");
  // Bit search
  a_msb_first: assert property ((first_pending_reg && dac_drive != 16'h0000)
    |-> dac_drive == 16'h8000)
    else $error("first trial is not the top bit");
  a_idle_dac: assert property (!busy |-> dac_drive == 16'h0000)
    else $error("trial pattern outside conversion");
  a_start_busy: assert property (($rose(convert_start) && !busy) |-> ##[1:5] busy)
    else $error("start edge not taken");
  a_conv_len: assert property ($rose(busy) |-> ##100 busy ##[BMIN:BMAX] !busy)
    else $error("conversion length wrong");
  // Span and clamp flag
  a_span_write: assert property ($rose(span_compress_en)
    |-> $past(psel && penable && pwrite && paddr == OFS_CTRL))
    else $error("span enabled without a write");
  a_clamp_set: assert property (clamp_active [*4] |=> overvoltage_clamp_flag)
    else $error("clamp flag not set");
  a_sticky_clr: assert property ($fell(overvoltage_clamp_flag)
    |-> $past(psel && penable && !pwrite && paddr == OFS_CLAMP))
    else $error("clamp flag cleared without a read");
  // Main scenarios
  c_done: cover property ($fell(busy));
  c_flag_clear: cover property ($fell(overvoltage_clamp_flag));
  c_span: cover property ($rose(span_compress_en));
endmodule

bind sar_conversion_sequencer sar_seq_checker #(.DIV(DIV)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .convert_start(convert_start), .clamp_active(clamp_active),
  .sample_switch_pos(sample_switch_pos), .sample_switch_neg(sample_switch_neg),
  .array_to_inputs(array_to_inputs), .dac_drive(dac_drive),
  .span_compress_en(span_compress_en), .busy(busy),
  .overvoltage_clamp_flag(overvoltage_clamp_flag));

// *** verification/testbench.sv ***
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module testbench;
  import sar_seq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic convert_start = 1'b0, clamp_active = 1'b0;
  logic [15:0] level = 16'h8000;
  logic [31:0] prdata, r;
  logic pready, pslverr, err, cmp, span, busy, ovf, irq;
  logic [15:0] dac, code;
  int fails = 0;
  int total_checks = 0;
  logic [15:0] levels [7] = '{16'h8000, 16'h8001, 16'h7fff, 16'h0001, 16'hffff, 16'h0000,
    16'ha5c3};

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  sar_conversion_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .convert_start(convert_start),
    .comp_trial_high(cmp), .clamp_active(clamp_active), .sample_switch_pos(),
    .sample_switch_neg(), .array_to_inputs(), .dac_drive(dac), .span_compress_en(span),
    .busy(busy), .result_code(code), .overvoltage_clamp_flag(ovf), .irq(irq));
  afe_model afe_u (.dac_drive(dac), .level(level), .comp_trial_high(cmp));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Start a conversion and wait for its end, then read the result
  task automatic conv(input logic [15:0] lv);
    int n;
    n = 0;
    level <= lv;
    convert_start <= 1'b1;
    // Busy is looked at on the falling edge, where it has settled
    while (busy !== 1'b1 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    convert_start <= 1'b0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    chk("conv end", busy, 1'b0);
    @(posedge pclk);
    apb(1'b0, OFS_RESULT, 32'h0000_0000);
  endtask

  task automatic final_report();
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(25 * 20000);
    fails++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk("ctrl reset", r, 32'h0000_0000);
    chk("span pin", span, 1'b0);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", err, 1'b1);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    // Code table, saturation ends included
    for (int i = 0; i < 7; i++) begin
      conv(levels[i]);
      chk("code", r[15:0], levels[i] ^ 16'h8000);
      chk("code pin", code, levels[i] ^ 16'h8000);
      chk("done irq", irq, 1'b1);
      apb(1'b1, OFS_IRQ_STAT, 32'h0000_0003);
      chk("irq clear", irq, 1'b0);
    end
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status", r[2:0], 3'b100);
    // Masked completion
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    conv(16'h8000);
    chk("masked irq", irq, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    chk("done status", r[0], 1'b1);
    // Span compression keeps the code range
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    chk("span on", span, 1'b1);
    // A write with its low strobe off leaves the span bit alone
    pstrb <= 4'h0;
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    chk("strobe off", span, 1'b1);
    pstrb <= 4'hf;
    conv(16'h0001);
    chk("span code", r[15:0], 16'h8001);
    // Clamp flag set, sticky, cleared by read
    clamp_active <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("clamp flag", ovf, 1'b1);
    conv(16'h8000);
    chk("result ov", r[16], 1'b1);
    clamp_active <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("flag sticky", ovf, 1'b1);
    apb(1'b0, OFS_CLAMP, 32'h0000_0000);
    chk("clamp read", r[0], 1'b1);
    chk("flag cleared", ovf, 1'b0);
    final_report();
  end
endmodule
